// ### dcsp_sync.sv
// Purpose: shared constants for the configuration serial port, and a two-stage pin synchroniser
// Assumes: single 200 MHz clock REF_CLK_IN, synchronous active-low reset
// Notes: synchroniser output is the only view of the pins that logic may read
package dcsp_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 16;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam int RW_BIT = 7;
  localparam int ADDR_MSB = 3;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] COARSE_ADDR = 4'h5;
  localparam int LSB_FIRST_BIT = 6;
  localparam int SWRST_BIT = 5;
  localparam int INTERP_PD_BIT = 4;
  localparam int IDAC_PD_BIT = 3;
  localparam int QDAC_PD_BIT = 2;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] COARSE_RESET = 8'h0f;
  localparam int SYNC_W = 3;
  // order is {cs_n, sclk, sdi}; chip select idles high
  localparam logic [SYNC_W-1:0] SYNC_RESET = 3'h4;
  localparam int SYNC_CS = 2;
  localparam int SYNC_SCLK = 1;
  localparam int SYNC_SDI = 0;
endpackage

`timescale 1ns/1ps
module dcsp_sync #(
  parameter int WIDTH = dcsp_pkg::SYNC_W,
  parameter logic [WIDTH-1:0] RESET_VAL = dcsp_pkg::SYNC_RESET
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stable_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      meta_reg <= RESET_VAL;
      stable_reg <= RESET_VAL;
    end else begin
      meta_reg <= d_in;
      stable_reg <= meta_reg;
    end
  end

  assign q_out = stable_reg;
endmodule // dcsp_sync

// ### dcsp_port.sv
// Purpose: configuration serial port slave with its 16 x 8-bit setting registers
// Assumes: host serial clock idles low and is far slower than REF_CLK_IN; pins sampled by dcsp_sync
// Notes: three-wire use works because the output is enabled only in the read data phase
// How it works
// - bits are taken on each rising serial clock edge only while select is low
// - with select high the input is ignored and the output is released
// - a transfer is one control byte and then one data byte
// - control byte is always written; data byte is written or read back
// - low four control bits pick the register for reads and writes
// - control bit seven chooses write when zero and read when one
// - by default each byte moves most significant bit first
// - in lsb-first mode both bytes move lowest bit first
// - on a read the addressed register is shifted out as the data byte
// - input and output may share one wire or stay separate
// - the port keeps working in every power-down state
// - both converters powered down also powers down the interpolators
`timescale 1ns/1ps
module dcsp_port (
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  input wire logic CS_N_IN,
  input wire logic SCLK_IN,
  input wire logic SDI_IN,
  output logic SDO_OUT,
  output logic SDO_OE_N_OUT,
  output logic LSB_FIRST_OUT,
  output logic IDAC_PD_OUT,
  output logic QDAC_PD_OUT,
  output logic INTERP_PD_OUT,
  output logic WR_STROBE_OUT,
  output logic [dcsp_pkg::ADDR_W-1:0] WR_ADDR_OUT,
  output logic [dcsp_pkg::DATA_W-1:0] WR_DATA_OUT
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CTRL = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } dcsp_state_type;

  typedef logic [dcsp_pkg::DATA_W-1:0] dcsp_byte_type;

  function automatic logic [dcsp_pkg::CNT_W-1:0] bit_idx(input logic lsb, input logic [dcsp_pkg::CNT_W-1:0] n);
    bit_idx = lsb ? n : dcsp_pkg::CNT_W'(dcsp_pkg::LAST_BIT - n);
  endfunction

  function automatic dcsp_byte_type reg_default(input int idx);
    reg_default = (idx == int'(dcsp_pkg::COARSE_ADDR)) ? dcsp_pkg::COARSE_RESET : dcsp_pkg::REG_RESET;
  endfunction

  logic [dcsp_pkg::SYNC_W-1:0] pins_s;
  logic cs_s;
  logic sclk_s;
  logic sdi_s;
  logic sclk_d_reg;
  logic rise;
  logic fall;
  logic lsb;

  dcsp_sync #(
    .WIDTH(dcsp_pkg::SYNC_W),
    .RESET_VAL(dcsp_pkg::SYNC_RESET)
  ) u_sync (
    .clk_in(REF_CLK_IN),
    .nrst_in(NRST_IN),
    .d_in({CS_N_IN, SCLK_IN, SDI_IN}),
    .q_out(pins_s)
  );

  assign cs_s = pins_s[dcsp_pkg::SYNC_CS];
  assign sclk_s = pins_s[dcsp_pkg::SYNC_SCLK];
  assign sdi_s = pins_s[dcsp_pkg::SYNC_SDI];

  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
    end
  end

  assign rise = sclk_s & ~sclk_d_reg;
  assign fall = ~sclk_s & sclk_d_reg;

  dcsp_state_type state_reg, state_next;
  logic [dcsp_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  dcsp_byte_type sr_reg, sr_next;
  dcsp_byte_type tx_reg, tx_next;
  logic rw_reg, rw_next;
  logic [dcsp_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic sdo_reg, sdo_next;
  logic strobe_reg, strobe_next;
  logic [dcsp_pkg::ADDR_W-1:0] wa_reg, wa_next;
  dcsp_byte_type wd_reg, wd_next;
  dcsp_byte_type regs_reg [dcsp_pkg::NUM_REGS];
  dcsp_byte_type regs_next [dcsp_pkg::NUM_REGS];
  dcsp_byte_type byte_now;

  // order change takes effect from the next transfer on
  assign lsb = regs_reg[dcsp_pkg::CTRL_ADDR][dcsp_pkg::LSB_FIRST_BIT];

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sr_next = sr_reg;
    tx_next = tx_reg;
    rw_next = rw_reg;
    addr_next = addr_reg;
    sdo_next = sdo_reg;
    strobe_next = 1'b0;
    wa_next = wa_reg;
    wd_next = wd_reg;
    regs_next = regs_reg;
    byte_now = sr_reg;
    byte_now[bit_idx(lsb, cnt_reg)] = sdi_s;
    if (cs_s) begin
      // abandoned bytes never reach the registers
      state_next = ST_IDLE;
      cnt_next = dcsp_pkg::CNT_ZERO;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_CTRL;
          cnt_next = dcsp_pkg::CNT_ZERO;
        end
        ST_CTRL: begin
          if (rise) begin
            sr_next = byte_now;
            cnt_next = dcsp_pkg::CNT_W'(cnt_reg + dcsp_pkg::CNT_ONE);
            if (cnt_reg == dcsp_pkg::LAST_BIT) begin
              // bits 4..6 are not checked; the host keeps them zero
              rw_next = byte_now[dcsp_pkg::RW_BIT];
              addr_next = byte_now[dcsp_pkg::ADDR_MSB:0];
              tx_next = regs_reg[byte_now[dcsp_pkg::ADDR_MSB:0]];
              state_next = ST_DATA;
              cnt_next = dcsp_pkg::CNT_ZERO;
            end
          end
        end
        ST_DATA: begin
          if (rise) begin
            sr_next = byte_now;
            cnt_next = dcsp_pkg::CNT_W'(cnt_reg + dcsp_pkg::CNT_ONE);
            if (cnt_reg == dcsp_pkg::LAST_BIT) begin
              state_next = ST_DONE;
              if (!rw_reg) begin
                strobe_next = 1'b1;
                wa_next = addr_reg;
                wd_next = byte_now;
                if (addr_reg == dcsp_pkg::CTRL_ADDR && byte_now[dcsp_pkg::SWRST_BIT]) begin
                  // soft reset clears itself by loading defaults
                  for (int i = 0; i < dcsp_pkg::NUM_REGS; i++) begin
                    regs_next[i] = reg_default(i);
                  end
                end else begin
                  regs_next[addr_reg] = byte_now;
                end
              end
            end
          end
          if (fall && rw_reg) begin
            sdo_next = tx_reg[bit_idx(lsb, cnt_reg)];
          end
        end
        ST_DONE: begin
          // extra clocks before select rises are ignored
          state_next = ST_DONE;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      state_reg <= ST_IDLE;
      cnt_reg <= dcsp_pkg::CNT_ZERO;
      sr_reg <= dcsp_pkg::REG_RESET;
      tx_reg <= dcsp_pkg::REG_RESET;
      rw_reg <= 1'b0;
      addr_reg <= dcsp_pkg::CTRL_ADDR;
      sdo_reg <= 1'b0;
      strobe_reg <= 1'b0;
      wa_reg <= dcsp_pkg::CTRL_ADDR;
      wd_reg <= dcsp_pkg::REG_RESET;
      for (int i = 0; i < dcsp_pkg::NUM_REGS; i++) begin
        regs_reg[i] <= reg_default(i);
      end
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sr_reg <= sr_next;
      tx_reg <= tx_next;
      rw_reg <= rw_next;
      addr_reg <= addr_next;
      sdo_reg <= sdo_next;
      strobe_reg <= strobe_next;
      wa_reg <= wa_next;
      wd_reg <= wd_next;
      regs_reg <= regs_next;
    end
  end

  // tally kept apart from the fsm counter so the checks below stand on their own
  localparam int FRAME_BITS = dcsp_pkg::DATA_W + dcsp_pkg::DATA_W;
  localparam int FB_W = $clog2(FRAME_BITS + 1);
  localparam logic [FB_W-1:0] FB_FULL = FB_W'(FRAME_BITS);
  localparam logic [FB_W-1:0] FB_CTRL = FB_W'(dcsp_pkg::DATA_W);
  localparam logic [FB_W-1:0] FB_ZERO = {FB_W{1'b0}};
  localparam logic [FB_W-1:0] FB_ONE = FB_W'(dcsp_pkg::CNT_ONE);

  logic [FB_W-1:0] fbits_reg, fbits_next;

  always_comb begin
    fbits_next = fbits_reg;
    if (cs_s) begin
      fbits_next = FB_ZERO;
    end else if (rise && state_reg != ST_IDLE && fbits_reg != FB_FULL) begin
      // saturates, so trailing clocks cannot wrap it
      fbits_next = FB_W'(fbits_reg + FB_ONE);
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      fbits_reg <= FB_ZERO;
    end else begin
      fbits_reg <= fbits_next;
    end
  end

  // nothing here is gated by the power-down bits, so the port stays alive
  assign SDO_OUT = sdo_reg;
  assign SDO_OE_N_OUT = ~(state_reg == ST_DATA && rw_reg && !cs_s);
  assign LSB_FIRST_OUT = lsb;
  assign IDAC_PD_OUT = regs_reg[dcsp_pkg::CTRL_ADDR][dcsp_pkg::IDAC_PD_BIT];
  assign QDAC_PD_OUT = regs_reg[dcsp_pkg::CTRL_ADDR][dcsp_pkg::QDAC_PD_BIT];
  assign INTERP_PD_OUT = regs_reg[dcsp_pkg::CTRL_ADDR][dcsp_pkg::INTERP_PD_BIT] |
                         (IDAC_PD_OUT & QDAC_PD_OUT);
  assign WR_STROBE_OUT = strobe_reg;
  assign WR_ADDR_OUT = wa_reg;
  assign WR_DATA_OUT = wd_reg;

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);

  a_release_when_idle: assert property (cs_s |-> SDO_OE_N_OUT)
    else $error("serial output driven while select high");
  a_abort_on_cs: assert property (cs_s |=> state_reg == ST_IDLE && cnt_reg == dcsp_pkg::CNT_ZERO)
    else $error("transfer not dropped on select high");
  a_count_on_rise: assert property ((rise && !cs_s && state_reg == ST_CTRL) |=>
    cnt_reg == dcsp_pkg::CNT_W'($past(cnt_reg) + dcsp_pkg::CNT_ONE) || state_reg == ST_DATA)
    else $error("bit not counted on rising edge");
  a_hold_no_rise: assert property ((!rise && !cs_s && state_reg != ST_IDLE) |=> $stable(sr_reg))
    else $error("shift register moved without rising edge");
  a_write_commit: assert property ((WR_STROBE_OUT && !(WR_ADDR_OUT == dcsp_pkg::CTRL_ADDR &&
    WR_DATA_OUT[dcsp_pkg::SWRST_BIT])) |-> regs_reg[WR_ADDR_OUT] == WR_DATA_OUT)
    else $error("written register does not hold data");
  a_strobe_cause: assert property (WR_STROBE_OUT |-> $past(state_reg == ST_DATA && cnt_reg == dcsp_pkg::LAST_BIT
    && rise && !rw_reg && !cs_s))
    else $error("write strobe without full data byte");
  a_interp_follow: assert property ((IDAC_PD_OUT && QDAC_PD_OUT) |-> INTERP_PD_OUT)
    else $error("interpolators not powered down");
  a_read_launch: assert property ((state_reg == ST_DATA && rw_reg && fall && !cs_s) |=>
    SDO_OUT == $past(tx_reg[bit_idx(lsb, cnt_reg)]))
    else $error("read bit not launched on falling edge");
  a_done_holds: assert property ((state_reg == ST_DONE && !cs_s) |=> state_reg == ST_DONE)
    else $error("extra bits accepted after data byte");
  a_read_tx_load: assert property ((state_reg == ST_CTRL && !cs_s && rise && cnt_reg == dcsp_pkg::LAST_BIT) |=>
    tx_reg == regs_reg[addr_reg])
    else $error("read data not taken from addressed register");

  a_strobe_full_frame: assert property (WR_STROBE_OUT |-> fbits_reg == FB_FULL)
    else $error("write strobe before sixteen bits");
  a_data_phase_span: assert property (state_reg == ST_DATA |-> fbits_reg >= FB_CTRL && fbits_reg < FB_FULL)
    else $error("data phase outside second byte");
  a_done_full_frame: assert property (state_reg == ST_DONE |-> fbits_reg == FB_FULL)
    else $error("frame closed before sixteen bits");
  a_drive_data_only: assert property (!SDO_OE_N_OUT |-> rw_reg && fbits_reg >= FB_CTRL && fbits_reg < FB_FULL)
    else $error("serial output driven outside read data byte");
  a_no_write_on_read: assert property (WR_STROBE_OUT |-> !rw_reg)
    else $error("register written during a read");
  a_cs_blocks_write: assert property (cs_s |=> !WR_STROBE_OUT)
    else $error("write committed while select high");
  a_sdo_on_fall: assert property (!fall |=> $stable(SDO_OUT))
    else $error("serial output moved without falling edge");
  a_ctrl_on_write: assert property (!WR_STROBE_OUT |-> $stable(regs_reg[dcsp_pkg::CTRL_ADDR]))
    else $error("control register changed without a write");
  a_alive_in_pd: assert property ((INTERP_PD_OUT && rise && !cs_s && state_reg == ST_CTRL) |=>
    cnt_reg != $past(cnt_reg))
    else $error("port stalled in power-down");
  a_soft_defaults: assert property ((WR_STROBE_OUT && WR_ADDR_OUT == dcsp_pkg::CTRL_ADDR &&
    WR_DATA_OUT[dcsp_pkg::SWRST_BIT]) |-> regs_reg[dcsp_pkg::COARSE_ADDR] == dcsp_pkg::COARSE_RESET &&
    regs_reg[dcsp_pkg::CTRL_ADDR] == dcsp_pkg::REG_RESET)
    else $error("soft reset did not restore defaults");

  c_write_done: cover property (WR_STROBE_OUT);
  c_read_done: cover property (state_reg == ST_DONE && rw_reg && cs_s);
  c_lsb_write: cover property (WR_STROBE_OUT && lsb);
  c_early_abort: cover property (state_reg == ST_DATA && cs_s && !rw_reg);
  c_lsb_read: cover property (!SDO_OE_N_OUT && lsb);
endmodule // dcsp_port

// ### dcsp_host.sv
// Purpose: host controller model driving the configuration serial port
// Assumes: serial clock idles low, half period of 16 reference cycles (80 ns)
// Notes: drives on the falling reference edge; a released data line toggles, never holds its last value
`timescale 1ns/1ps
module dcsp_host (
  input wire logic clk_in,
  input wire logic miso_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic mosi_out,
  output logic mosi_oe_out
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
    mosi_oe_out = 1'b1;
  end
  task automatic half();
    repeat (16) @(negedge clk_in);
  endtask
  // nbits below 16 cuts the transfer short by raising select early
  task automatic xfer(input logic rd, input logic [3:0] addr, input logic [7:0] wd, input logic lsb, input int nbits,
                      output logic [7:0] rdat);
    logic [15:0] w;
    int k;
    w = {rd, 3'h0, addr, wd};
    rdat = 8'h00;
    @(negedge clk_in);
    cs_n_out = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      k = !lsb ? 15 - i : (i < 8 ? i + 8 : i - 8);
      mosi_oe_out = !(rd && i > 7);
      mosi_out = mosi_oe_out ? w[k] : ~mosi_out;
      half();
      sclk_out = 1'b1;
      if (rd && i > 7) rdat[k] = miso_in;
      half();
      sclk_out = 1'b0;
    end
    half();
    cs_n_out = 1'b1;
    mosi_oe_out = 1'b1;
    half();
  endtask
  // clock and data wiggle with select high
  task automatic noise();
    for (int i = 0; i < 8; i++) begin
      mosi_out = ~mosi_out;
      sclk_out = ~sclk_out;
      half();
    end
  endtask
endmodule // dcsp_host

// ### tb_top.sv
// Purpose: self-checking bench for the configuration serial port
// Assumes: 200 MHz reference clock, host model at an 80 ns serial half period
// Notes: three-wire mode resolves one shared line from both enables
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic three = 1'b0;
  logic lsb = 1'b0;
  logic cs_n, sclk, mosi, mosi_oe, sdo, oe_n, lsb_o, ipd, qpd, interp, stb, line, miso, sdi;
  logic [3:0] wa;
  logic [7:0] wdt;
  int fails = 0;
  int samples_checked = 0;
  int strobes = 0;
  always #2.5 clk = ~clk;
  // undriven wire shows the inverse of the device output, so a stale bit cannot pass
  assign line = !oe_n ? sdo : (mosi_oe ? mosi : ~sdo);
  assign sdi = three ? line : mosi;
  assign miso = three ? line : (oe_n ? ~sdo : sdo);
  dcsp_host h_u (.clk_in(clk), .miso_in(miso), .cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi),
    .mosi_oe_out(mosi_oe));
  dcsp_port dut_u (.REF_CLK_IN(clk), .NRST_IN(nrst), .CS_N_IN(cs_n), .SCLK_IN(sclk), .SDI_IN(sdi), .SDO_OUT(sdo),
    .SDO_OE_N_OUT(oe_n), .LSB_FIRST_OUT(lsb_o), .IDAC_PD_OUT(ipd), .QDAC_PD_OUT(qpd), .INTERP_PD_OUT(interp),
    .WR_STROBE_OUT(stb), .WR_ADDR_OUT(wa), .WR_DATA_OUT(wdt));
  always @(posedge clk) if (stb === 1'b1) strobes++;
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    int n0;
    n0 = strobes;
    h_u.xfer(1'b0, a, d, lsb, 16, r);
    chk("strobe_count", 8'(n0 + 1), 8'(strobes));
    chk("wr_addr", {4'h0, a}, {4'h0, wa});
    chk("wr_data", d, wdt);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] r;
    h_u.xfer(1'b1, a, 8'h00, lsb, 16, r);
    chk("rd_data", e, r);
    chk("oe_idle", 8'h01, {7'h0, oe_n});
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    conclude();
  end
  initial begin
    logic [7:0] r;
    int n;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk("pd_reset", 8'h00, {4'h0, lsb_o, ipd, qpd, interp});
    chk("oe_reset", 8'h01, {7'h0, oe_n});
    rd(4'h5, 8'h0f);
    $display("test reset done");
    for (int a = 1; a < 16; a++) wr(4'(a), 8'h5a ^ 8'(a * 17));
    for (int a = 1; a < 16; a++) rd(4'(a), 8'h5a ^ 8'(a * 17));
    $display("test write_read done");
    n = strobes;
    h_u.xfer(1'b0, 4'h4, 8'hff, 1'b0, 12, r);
    chk("abort_strobe", 8'(n), 8'(strobes));
    rd(4'h4, 8'h5a ^ 8'h44);
    h_u.noise();
    chk("noise_strobe", 8'(n), 8'(strobes));
    chk("noise_oe", 8'h01, {7'h0, oe_n});
    rd(4'h4, 8'h5a ^ 8'h44);
    $display("test abort_noise done");
    wr(4'h0, 8'h0c);
    chk("pd_both", 8'h07, {5'h0, ipd, qpd, interp});
    rd(4'h0, 8'h0c);
    wr(4'h3, 8'h81);
    rd(4'h3, 8'h81);
    wr(4'h0, 8'h08);
    chk("pd_one", 8'h04, {5'h0, ipd, qpd, interp});
    wr(4'h0, 8'h10);
    chk("pd_interp", 8'h01, {5'h0, ipd, qpd, interp});
    $display("test power_down done");
    wr(4'h0, 8'h40);
    lsb = 1'b1;
    chk("lsb_out", 8'h01, {7'h0, lsb_o});
    wr(4'h9, 8'h96);
    rd(4'h9, 8'h96);
    rd(4'h5, 8'h0f);
    three = 1'b1;
    rd(4'h9, 8'h96);
    wr(4'h0, 8'h00);
    lsb = 1'b0;
    rd(4'h9, 8'h96);
    $display("test lsb_three_wire done");
    wr(4'h0, 8'h20);
    rd(4'h0, 8'h00);
    rd(4'h9, 8'h00);
    rd(4'h5, 8'h0f);
    $display("test soft_reset done");
    conclude();
  end
endmodule // tb_top
